// >>> verilog/pafe_pkg.sv
// Constants and types of the front-end serial register block.
//
// Behaviour
// - Every register holds twelve bits, bit 0 least significant.
// - Frame is R/W bit, three address bits, twelve data bits.
// - Data changes on falling serial clock, sampled on rising edge.
// - Select high returns the frame machine to the R/W state.
// - Write frames load the addressed register on the sixteenth edge.
// - Three address bits decode eight twelve-bit slots.
// - Map: 0 sample, 1 flags, 2 gain 003h, 3 enables 12Ch, 4 identity.
// - Sample field sits in bits 9 to 0.
// - Overcurrent flag bit 2 latches, cleared by writing 0.
// - Thermal flag bit 1 latches, cleared by writing 0.
// - Gain bits 7-6 and 5-4 select the two receive gains.
// - Gain bits 3-2 select transmit gain, 1-0 current limit.
// - Enable bit 9 switches the zero-crossing detectors.
// - Enable bit 8 selects the narrow receive band.
// - Enable bits 7, 6, 5, 3 switch amplifier and chains.
// - Enable bit 4 selects the internal DAC.
// - Enable bit 2 switches the receive high-pass filter.
// - Writing enable bit 1 resets all registers and the serial logic.
// - Enable bit 0 powers down blocks; registers and serial stay.
// - Enable pin low lowers power, keeps registers and transfers.
// - Power-on reset returns every register to its default.
// - A latched fault flag drives the fault interrupt output.
package pafe_pkg;
  localparam int unsigned REG_W      = 12;
  localparam int unsigned ADDR_W     = 3;
  localparam int unsigned CNT_W      = 4;
  localparam logic [3:0]  CNT_HDR_END = 4'h3;
  localparam logic [3:0]  CNT_DATA1  = 4'h4;
  localparam logic [3:0]  CNT_LAST   = 4'hF;
  localparam logic [2:0]  ADDR_SAMPLE  = 3'h0;
  localparam logic [2:0]  ADDR_FLAGS   = 3'h1;
  localparam logic [2:0]  ADDR_GAIN    = 3'h2;
  localparam logic [2:0]  ADDR_ENABLES = 3'h3;
  localparam logic [2:0]  ADDR_IDENT   = 3'h4;
  localparam logic [11:0] RST_SAMPLE  = 12'h000;
  localparam logic [11:0] RST_GAIN    = 12'h003;
  localparam logic [11:0] RST_ENABLES = 12'h12C;
  // Identity values are arbitrary.
  localparam logic [4:0]  IDENT_NUMBER   = 5'h0A;
  localparam logic [2:0]  IDENT_REVISION = 3'h2;
  localparam int unsigned SAMPLE_MSB = 9;
  localparam int unsigned FLAG_OVC   = 2;
  localparam int unsigned FLAG_THERM = 1;
  localparam int unsigned GAIN_RX2   = 6;
  localparam int unsigned GAIN_RX1   = 4;
  localparam int unsigned GAIN_TX    = 2;
  localparam int unsigned GAIN_ILIM  = 0;
  localparam int unsigned EN_ZC      = 9;
  localparam int unsigned EN_BAND    = 8;
  localparam int unsigned EN_PA      = 7;
  localparam int unsigned EN_TX      = 6;
  localparam int unsigned EN_RX      = 5;
  localparam int unsigned EN_DAC     = 4;
  localparam int unsigned EN_PAN     = 3;
  localparam int unsigned EN_HP      = 2;
  localparam int unsigned EN_SRST    = 1;
  localparam int unsigned EN_PD      = 0;
  localparam logic [5:0]  PIN_RST    = 6'h20;
  typedef enum logic [0:0] {PH_HEADER, PH_DATA} pafe_phase_t;
endpackage

// >>> verilog/pafe_reg_if.sv
// Carrier between the frame logic and the register bank.
`timescale 1ns/1ps
interface pafe_reg_if;
  logic        wr_en;
  logic [2:0]  addr;
  logic [11:0] wdata;
  logic [11:0] rdata;
  logic [11:0] sample;
  logic [11:0] gain;
  logic [11:0] enables;
  logic [1:0]  flags;
  logic        soft_rst;
  modport bank (input wr_en, addr, wdata,
                output rdata, sample, gain, enables, flags, soft_rst);
  modport frame (output wr_en, addr, wdata,
                 input rdata, sample, gain, enables, flags, soft_rst);
endinterface

// >>> verilog/pafe_sync.sv
// Two-stage synchroniser for pin inputs.
`timescale 1ns/1ps
module pafe_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic         clk_en,
  // Data
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      meta_q   <= RST_VAL;
      pin_sync <= RST_VAL;
    end else if (clk_en) begin
      meta_q   <= pin_in;
      pin_sync <= meta_q;
    end
  end
endmodule // pafe_sync

// >>> verilog/pafe_reg_bank.sv
// Register bank: sample, fault flags, gain, enables and identity.
`timescale 1ns/1ps
module pafe_reg_bank (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic clk_en,
  // Fault events
  input  wire logic ovc_evt,
  input  wire logic therm_evt,
  // Register access
  pafe_reg_if.bank  rif
);
  logic [11:0] sample_q, gain_q, enables_q, rdata_q;
  logic        ovc_q, therm_q, srst_q;
  logic [11:0] ident_word;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] t);
    hit = (a == t);
  endfunction

  assign ident_word = {4'h0, pafe_pkg::IDENT_NUMBER, pafe_pkg::IDENT_REVISION};
  assign rif.rdata = rdata_q;
  assign rif.sample = sample_q;
  assign rif.gain = gain_q;
  assign rif.enables = enables_q;
  assign rif.flags = {ovc_q, therm_q};
  assign rif.soft_rst = srst_q;

  // Soft reset pulse, one cycle after the write.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      srst_q <= 1'b0;
    end else if (clk_en) begin
      srst_q <= rif.wr_en && hit(rif.addr, pafe_pkg::ADDR_ENABLES)
                && rif.wdata[pafe_pkg::EN_SRST];
    end
  end

  // Writable registers; power-on and soft reset give defaults.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sample_q  <= pafe_pkg::RST_SAMPLE;
      gain_q    <= pafe_pkg::RST_GAIN;
      enables_q <= pafe_pkg::RST_ENABLES;
    end else if (clk_en) begin
      if (srst_q) begin
        sample_q  <= pafe_pkg::RST_SAMPLE;
        gain_q    <= pafe_pkg::RST_GAIN;
        enables_q <= pafe_pkg::RST_ENABLES;
      end else if (rif.wr_en) begin
        if (hit(rif.addr, pafe_pkg::ADDR_SAMPLE)) begin
          sample_q <= rif.wdata;
        end
        if (hit(rif.addr, pafe_pkg::ADDR_GAIN)) begin
          gain_q <= rif.wdata;
        end
        if (hit(rif.addr, pafe_pkg::ADDR_ENABLES)) begin
          enables_q <= rif.wdata;
        end
      end
    end
  end

  // Fault flags: a new event wins over any clear.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ovc_q   <= 1'b0;
      therm_q <= 1'b0;
    end else if (clk_en) begin
      if (ovc_evt) begin
        ovc_q <= 1'b1;
      end else if (srst_q || (rif.wr_en && hit(rif.addr, pafe_pkg::ADDR_FLAGS)
                   && !rif.wdata[pafe_pkg::FLAG_OVC])) begin
        ovc_q <= 1'b0;
      end
      if (therm_evt) begin
        therm_q <= 1'b1;
      end else if (srst_q || (rif.wr_en && hit(rif.addr, pafe_pkg::ADDR_FLAGS)
                   && !rif.wdata[pafe_pkg::FLAG_THERM])) begin
        therm_q <= 1'b0;
      end
    end
  end

  // Registered read mux; unmapped slots read zero.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdata_q <= 12'h000;
    end else if (clk_en) begin
      case (rif.addr)
        pafe_pkg::ADDR_SAMPLE:  rdata_q <= {2'h0, sample_q[9:0]};
        pafe_pkg::ADDR_FLAGS:   rdata_q <= {9'h000, ovc_q, therm_q, 1'b0};
        pafe_pkg::ADDR_GAIN:    rdata_q <= gain_q;
        pafe_pkg::ADDR_ENABLES: rdata_q <= enables_q;
        pafe_pkg::ADDR_IDENT:   rdata_q <= ident_word;
        default:                rdata_q <= 12'h000;
      endcase
    end
  end

  AST_SOFT_DEFAULTS: assert property (@(posedge clock) disable iff (reset)
    clk_en && rif.wr_en && hit(rif.addr, pafe_pkg::ADDR_ENABLES)
    && rif.wdata[pafe_pkg::EN_SRST] ##1 clk_en
    |=> enables_q == pafe_pkg::RST_ENABLES && gain_q == pafe_pkg::RST_GAIN)
    else $error("Soft reset did not restore defaults.");

  AST_SRST_SELF_CLEAR: assert property (@(posedge clock) disable iff (reset)
    clk_en && srst_q |=> !enables_q[pafe_pkg::EN_SRST])
    else $error("Soft-reset bit did not clear itself.");

  AST_OVC_CLEAR: assert property (@(posedge clock) disable iff (reset)
    clk_en && !ovc_evt && rif.wr_en && hit(rif.addr, pafe_pkg::ADDR_FLAGS)
    && !rif.wdata[pafe_pkg::FLAG_OVC] |=> !ovc_q)
    else $error("Overcurrent flag not cleared by writing 0.");

  AST_THERM_SET: assert property (@(posedge clock) disable iff (reset)
    clk_en && therm_evt |=> therm_q)
    else $error("Thermal flag did not latch.");
endmodule // pafe_reg_bank

// >>> verilog/pafe_spi_regs.sv
// Top of the front-end serial slave and its register bank.
`timescale 1ns/1ps
module pafe_spi_regs (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       clk_en,
  // Serial link pins
  input  wire logic       serial_select_n,
  input  wire logic       sclk,
  input  wire logic       din,
  output logic            dout,
  output logic            dout_oe_n,
  // Device pins and analog fault conditions
  input  wire logic       enable_pin,
  input  wire logic       ovc_fault,
  input  wire logic       therm_fault,
  output logic            fault_irq,
  // Sample to the DAC
  output logic [9:0]      dac_sample,
  // Gain controls
  output logic [1:0]      rx_second_gain,
  output logic [1:0]      rx_first_gain,
  output logic [1:0]      tx_gain_sel,
  output logic [1:0]      current_limit_sel,
  // Block enables
  output logic            zero_cross_on,
  output logic            narrow_band_sel,
  output logic            amp_both_on,
  output logic            tx_chain_on,
  output logic            rx_chain_on,
  output logic            int_dac_on,
  output logic            amp_neg_half_on,
  output logic            highpass_on,
  output logic            power_down_bit,
  output logic            low_power
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  pafe_reg_if rif ();

  logic [5:0]            pins_sync;
  logic                  sel_s;
  logic                  sclk_s;
  logic                  din_s;
  logic                  en_s;
  logic                  ovc_s;
  logic                  therm_s;
  logic                  sclk_prev_q;
  logic                  ovc_prev_q;
  logic                  therm_prev_q;
  logic                  rise;
  logic                  fall;
  logic                  ovc_evt;
  logic                  therm_evt;
  logic                  frame_clr;
  pafe_pkg::pafe_phase_t phase_q;
  logic [3:0]            cnt_q;
  logic                  rw_q;
  logic [2:0]            addr_q;
  logic [11:0]           shin_q;
  logic [11:0]           shout_q;
  logic                  wr_en_q;
  logic [11:0]           wdata_q;
  logic                  dout_q;
  logic                  dout_oe_n_q;
  logic                  irq_q;
  logic                  low_power_q;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  pafe_sync #(
    .W       (6),
    .RST_VAL (pafe_pkg::PIN_RST)
  ) u_sync (
    .clock    (clock),
    .reset    (reset),
    .clk_en   (clk_en),
    .pin_in   ({serial_select_n, sclk, din, enable_pin, ovc_fault,
                therm_fault}),
    .pin_sync (pins_sync)
  );

  assign sel_s   = pins_sync[5];
  assign sclk_s  = pins_sync[4];
  assign din_s   = pins_sync[3];
  assign en_s    = pins_sync[2];
  assign ovc_s   = pins_sync[1];
  assign therm_s = pins_sync[0];

  // ****************************************************************
  // Edge detection
  // ****************************************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sclk_prev_q  <= 1'b0;
      ovc_prev_q   <= 1'b0;
      therm_prev_q <= 1'b0;
    end else if (clk_en) begin
      sclk_prev_q  <= sclk_s;
      ovc_prev_q   <= ovc_s;
      therm_prev_q <= therm_s;
    end
  end

  // Serial clock edges only count while the slave is selected.
  assign rise      = !sel_s && sclk_s && !sclk_prev_q;
  assign fall      = !sel_s && !sclk_s && sclk_prev_q;
  assign ovc_evt   = ovc_s && !ovc_prev_q;
  assign therm_evt = therm_s && !therm_prev_q;
  assign frame_clr = sel_s || rif.soft_rst;

  // ****************************************************************
  // Frame state machine
  // ****************************************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      phase_q <= pafe_pkg::PH_HEADER;
    end else if (clk_en) begin
      if (frame_clr) begin
        phase_q <= pafe_pkg::PH_HEADER;
      end else if (rise) begin
        case (phase_q)
          pafe_pkg::PH_HEADER: begin
            if (cnt_q == pafe_pkg::CNT_HDR_END) begin
              phase_q <= pafe_pkg::PH_DATA;
            end
          end
          pafe_pkg::PH_DATA: begin
            if (cnt_q == pafe_pkg::CNT_LAST) begin
              phase_q <= pafe_pkg::PH_HEADER;
            end
          end
          default: begin
            phase_q <= pafe_pkg::PH_HEADER;
          end
        endcase
      end
    end
  end

  // Edge counter; wraps for back-to-back frames under one select.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_q <= 4'h0;
    end else if (clk_en) begin
      if (frame_clr) begin
        cnt_q <= 4'h0;
      end else if (rise) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // ****************************************************************
  // Header capture
  // ****************************************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rw_q   <= 1'b0;
      addr_q <= 3'h0;
    end else if (clk_en) begin
      if (rise && phase_q == pafe_pkg::PH_HEADER) begin
        if (cnt_q == 4'h0) begin
          rw_q <= din_s;
        end else begin
          addr_q <= {addr_q[1:0], din_s};
        end
      end
    end
  end

  // ****************************************************************
  // Data capture and write strobe
  // ****************************************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      shin_q <= 12'h000;
    end else if (clk_en) begin
      if (rise && phase_q == pafe_pkg::PH_DATA) begin
        shin_q <= {shin_q[10:0], din_s};
      end
    end
  end

  // The word is complete on the sixteenth rising edge.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wr_en_q <= 1'b0;
      wdata_q <= 12'h000;
    end else if (clk_en) begin
      wr_en_q <= rise && !frame_clr && phase_q == pafe_pkg::PH_DATA
                 && cnt_q == pafe_pkg::CNT_LAST && !rw_q;
      if (rise && cnt_q == pafe_pkg::CNT_LAST) begin
        wdata_q <= {shin_q[10:0], din_s};
      end
    end
  end

  assign rif.wr_en = wr_en_q;
  assign rif.addr  = addr_q;
  assign rif.wdata = wdata_q;

  // ****************************************************************
  // Read data shifter
  // ****************************************************************
  // The first data bit leaves on the falling edge after the address.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      shout_q <= 12'h000;
      dout_q  <= 1'b0;
    end else if (clk_en) begin
      if (frame_clr) begin
        shout_q <= 12'h000;
        dout_q  <= 1'b0;
      end else if (fall) begin
        if (phase_q == pafe_pkg::PH_DATA && rw_q) begin
          if (cnt_q == pafe_pkg::CNT_DATA1) begin
            dout_q  <= rif.rdata[11];
            shout_q <= {rif.rdata[10:0], 1'b0};
          end else begin
            dout_q  <= shout_q[11];
            shout_q <= {shout_q[10:0], 1'b0};
          end
        end else begin
          dout_q <= 1'b0;
        end
      end
    end
  end

  // Output is released whenever select is high.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dout_oe_n_q <= 1'b1;
    end else if (clk_en) begin
      dout_oe_n_q <= sel_s;
    end
  end

  // ****************************************************************
  // Register bank
  // ****************************************************************
  pafe_reg_bank u_bank (
    .clock     (clock),
    .reset     (reset),
    .clk_en    (clk_en),
    .ovc_evt   (ovc_evt),
    .therm_evt (therm_evt),
    .rif       (rif.bank)
  );

  // ****************************************************************
  // Interrupt and power state
  // ****************************************************************
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq_q <= 1'b0;
    end else if (clk_en) begin
      irq_q <= |rif.flags;
    end
  end

  // Neither the pin nor the bit touches register contents.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      low_power_q <= 1'b0;
    end else if (clk_en) begin
      low_power_q <= !en_s || rif.enables[pafe_pkg::EN_PD];
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign dout              = dout_q;
  assign dout_oe_n         = dout_oe_n_q;
  assign fault_irq         = irq_q;
  assign low_power         = low_power_q;
  assign dac_sample        = rif.sample[pafe_pkg::SAMPLE_MSB:0];
  assign rx_second_gain    = rif.gain[pafe_pkg::GAIN_RX2 +: 2];
  assign rx_first_gain     = rif.gain[pafe_pkg::GAIN_RX1 +: 2];
  assign tx_gain_sel       = rif.gain[pafe_pkg::GAIN_TX +: 2];
  assign current_limit_sel = rif.gain[pafe_pkg::GAIN_ILIM +: 2];
  assign zero_cross_on     = rif.enables[pafe_pkg::EN_ZC];
  assign narrow_band_sel   = rif.enables[pafe_pkg::EN_BAND];
  assign amp_both_on       = rif.enables[pafe_pkg::EN_PA];
  assign tx_chain_on       = rif.enables[pafe_pkg::EN_TX];
  assign rx_chain_on       = rif.enables[pafe_pkg::EN_RX];
  assign int_dac_on        = rif.enables[pafe_pkg::EN_DAC];
  assign amp_neg_half_on   = rif.enables[pafe_pkg::EN_PAN];
  assign highpass_on       = rif.enables[pafe_pkg::EN_HP];
  assign power_down_bit    = rif.enables[pafe_pkg::EN_PD];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_SELECT_IDLE: assert property (@(posedge clock) disable iff (reset)
    clk_en && sel_s |=> cnt_q == 4'h0 && phase_q == pafe_pkg::PH_HEADER)
    else $error("Select high did not return the frame to its start.");

  AST_WRITE_EDGE16: assert property (@(posedge clock) disable iff (reset)
    clk_en && rise && !frame_clr && phase_q == pafe_pkg::PH_DATA
    && cnt_q == pafe_pkg::CNT_LAST && !rw_q |=> wr_en_q && cnt_q == 4'h0)
    else $error("Write strobe missing on the sixteenth edge.");

  AST_NO_WRITE_ON_READ: assert property (@(posedge clock) disable iff (reset)
    $past(clk_en) && wr_en_q |-> !rw_q && $past(cnt_q) == pafe_pkg::CNT_LAST)
    else $error("Write strobe outside a write frame.");

  AST_OE_FOLLOWS_SELECT: assert property (@(posedge clock) disable iff (reset)
    clk_en && sel_s |=> dout_oe_n_q && !dout_q)
    else $error("Data output not released while deselected.");

  AST_IRQ_ON_FLAG: assert property (@(posedge clock) disable iff (reset)
    clk_en && rif.flags != 2'h0 |=> irq_q)
    else $error("Fault interrupt not raised for a latched flag.");

  AST_LOW_POWER_PIN: assert property (@(posedge clock) disable iff (reset)
    clk_en && !en_s |=> low_power_q)
    else $error("Enable pin low did not enter low power.");

endmodule // pafe_spi_regs

// >>> tb/pafe_host_model.sv
// Host model that runs serial frames against the register block.
`timescale 1ns/1ps
module pafe_host_model (
  // Link pins
  output logic      serial_select_n,
  output logic      sclk,
  output logic      din,
  input  wire logic dout
);
  initial begin
    serial_select_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  // Sends n bits of a frame; a short count raises select early and aborts it.
  task automatic xfer(input logic cpol, input logic rw, input logic [2:0] a,
                      input logic [11:0] d, input int n, output logic [11:0] rd);
    logic [15:0] w;
    w = {rw, a, d};
    rd = 12'h000;
    sclk = cpol;
    // The idle clock level settles while deselected, so it is never taken as an edge.
    #213 serial_select_n = 1'b0;
    #200;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      din = w[15-i];
      #200 sclk = 1'b1;
      if (i > 3) rd = {rd[10:0], dout};
      #200;
    end
    sclk = cpol;
    #200 serial_select_n = 1'b1;
    din = ~din;
    #400;
  endtask
endmodule // pafe_host_model

// >>> tb/pafe_spi_regs_bench.sv
// Self-checking bench for the serial register block.
`timescale 1ns/1ps
module pafe_spi_regs_bench;
  logic        clock, reset, clk_en, sel_n, sclk, din, dout, dout_oe_n;
  logic        enable_pin, ovc_fault, therm_fault, fault_irq, low_power;
  logic [9:0]  dac_sample;
  logic [1:0]  rx2, rx1, txg, ilim;
  logic        zc, nb, pa, txc, rxc, dac, pan, hp, pd;
  logic [11:0] rd;
  int          failures = 0;
  int          tests_run = 0;
  pafe_spi_regs u_dut (.clock(clock), .reset(reset), .clk_en(clk_en),
    .serial_select_n(sel_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe_n(dout_oe_n),
    .enable_pin(enable_pin), .ovc_fault(ovc_fault), .therm_fault(therm_fault),
    .fault_irq(fault_irq), .dac_sample(dac_sample), .rx_second_gain(rx2),
    .rx_first_gain(rx1), .tx_gain_sel(txg), .current_limit_sel(ilim), .zero_cross_on(zc),
    .narrow_band_sel(nb), .amp_both_on(pa), .tx_chain_on(txc), .rx_chain_on(rxc),
    .int_dac_on(dac), .amp_neg_half_on(pan), .highpass_on(hp), .power_down_bit(pd),
    .low_power(low_power));
  pafe_host_model u_host (.serial_select_n(sel_n), .sclk(sclk), .din(din), .dout(dout));
  always #25 clock = ~clock;
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xf(input logic m, input logic rw, input logic [2:0] a,
                    input logic [11:0] d, input int n);
    @(posedge clock);
    u_host.xfer(m, rw, a, d, n, rd);
  endtask
  task automatic rc(input logic [2:0] a, input logic [11:0] e);
    xf(1'b0, 1'b1, a, 12'h000, 16);
    chk(rd, e);
  endtask
  function automatic logic [11:0] en_pins();
    return {2'b00, zc, nb, pa, txc, rxc, dac, pan, hp, 1'b0, pd};
  endfunction
  function automatic logic [11:0] gain_pins();
    return {4'h0, rx2, rx1, txg, ilim};
  endfunction
  task automatic t_defaults();
    rc(pafe_pkg::ADDR_SAMPLE, 12'h000);
    rc(pafe_pkg::ADDR_FLAGS, 12'h000);
    rc(pafe_pkg::ADDR_GAIN, 12'h003);
    rc(pafe_pkg::ADDR_ENABLES, 12'h12C);
    chk(gain_pins(), 12'h003);
    chk(en_pins(), 12'h12C);
    chk({11'h000, dout_oe_n}, 12'h001);
  endtask
  task automatic t_modes();
    xf(1'b1, 1'b0, pafe_pkg::ADDR_SAMPLE, 12'hEA5, 16);
    chk({2'b00, dac_sample}, 12'h2A5);
    xf(1'b1, 1'b1, pafe_pkg::ADDR_SAMPLE, 12'h000, 16);
    chk(rd, 12'h2A5);
    xf(1'b0, 1'b0, pafe_pkg::ADDR_SAMPLE, 12'h15A, 16);
    rc(pafe_pkg::ADDR_SAMPLE, 12'h15A);
  endtask
  task automatic t_gain_abort();
    xf(1'b0, 1'b0, pafe_pkg::ADDR_GAIN, 12'h0E4, 16);
    chk(gain_pins(), 12'h0E4);
    xf(1'b0, 1'b0, pafe_pkg::ADDR_GAIN, 12'h0FF, 15);
    rc(pafe_pkg::ADDR_GAIN, 12'h0E4);
  endtask
  task automatic t_readonly();
    xf(1'b0, 1'b0, pafe_pkg::ADDR_IDENT, 12'hFFF, 16);
    rc(pafe_pkg::ADDR_IDENT, {4'h0, pafe_pkg::IDENT_NUMBER, pafe_pkg::IDENT_REVISION});
    rc(3'h5, 12'h000);
  endtask
  task automatic t_faults();
    // A fault raised while the clock enable is low must wait until it returns.
    @(posedge clock);
    clk_en <= 1'b0;
    ovc_fault <= 1'b1;
    repeat (6) @(posedge clock);
    chk({11'h000, fault_irq}, 12'h000);
    clk_en <= 1'b1;
    repeat (6) @(posedge clock);
    chk({11'h000, fault_irq}, 12'h001);
    therm_fault <= 1'b1;
    ovc_fault <= 1'b0;
    repeat (6) @(posedge clock);
    therm_fault <= 1'b0;
    rc(pafe_pkg::ADDR_FLAGS, 12'h006);
    xf(1'b0, 1'b0, pafe_pkg::ADDR_FLAGS, 12'h002, 16);
    rc(pafe_pkg::ADDR_FLAGS, 12'h002);
    xf(1'b0, 1'b0, pafe_pkg::ADDR_FLAGS, 12'h000, 16);
    rc(pafe_pkg::ADDR_FLAGS, 12'h000);
    chk({11'h000, fault_irq}, 12'h000);
  endtask
  task automatic t_power();
    enable_pin <= 1'b0;
    xf(1'b0, 1'b0, pafe_pkg::ADDR_GAIN, 12'h055, 16);
    chk({11'h000, low_power}, 12'h001);
    rc(pafe_pkg::ADDR_GAIN, 12'h055);
    enable_pin <= 1'b1;
    xf(1'b0, 1'b0, pafe_pkg::ADDR_ENABLES, 12'h12D, 16);
    chk({10'h000, pd, low_power}, 12'h003);
    rc(pafe_pkg::ADDR_GAIN, 12'h055);
  endtask
  task automatic t_soft_reset();
    xf(1'b0, 1'b0, pafe_pkg::ADDR_ENABLES, 12'h3C3, 16);
    rc(pafe_pkg::ADDR_ENABLES, 12'h12C);
    rc(pafe_pkg::ADDR_GAIN, 12'h003);
    rc(pafe_pkg::ADDR_SAMPLE, 12'h000);
    chk(en_pins(), 12'h12C);
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    clk_en = 1'b1;
    enable_pin = 1'b1;
    ovc_fault = 1'b0;
    therm_fault = 1'b0;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    repeat (5) @(posedge clock);
    t_defaults();
    t_modes();
    t_gain_abort();
    t_readonly();
    t_faults();
    t_power();
    t_soft_reset();
    summarize();
  end
  initial begin
    #1000000;
    failures++;
    summarize();
  end
endmodule // pafe_spi_regs_bench
